// ### tb/clock_mode_reset_watchdog_checker.sv
// Purpose: port-level checks of the reset sequencer and clock modes
// Assumes: sees only the top-level ports
// Notes:   pin input is synced in the design, hence the lag allowances
module clock_mode_reset_watchdog_checker (
   // clock and reset
   input wire logic                                    CLK_I,
   input wire logic                                    NRST_I,
   // observed ports
   input wire clock_mode_reset_watchdog_pkg::pins_type      PINS_I,
   input wire logic                                    GLOBAL_MASK_I,
   input wire logic                                    RESET_PIN_O,
   input wire logic                                    RESET_PIN_OE_O,
   input wire logic                                    INT_RESET_O,
   input wire logic [1:0]                              VECTOR_O,
   input wire clock_mode_reset_watchdog_pkg::clock_ctl_type CLOCK_O,
   input wire logic [5:0]                              IRQ_O
);
   timeunit 1ns;
   timeprecision 1ns;
   import clock_mode_reset_watchdog_pkg::*;
   logic [9:0] oe_run;
   // saturates so a pin held low for long cannot wrap the count
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) oe_run <= 10'h000;
      else oe_run <= RESET_PIN_OE_O ? oe_run + {9'h000, oe_run != 10'h3ff} : 10'h000;
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   a_pin_driven_low: assert property (RESET_PIN_OE_O |-> !RESET_PIN_O)
      else $error("reset pin driven high");
   a_drive_length: assert property ($fell(RESET_PIN_OE_O) |-> oe_run >= 10'd512)
      else $error("pin drive too short");
   a_wait_length: assert property ($fell(INT_RESET_O) |-> $past(RESET_PIN_OE_O, 64) == 1'b0)
      else $error("wait phase too short");
   a_int_covers_drive: assert property (RESET_PIN_OE_O |-> INT_RESET_O)
      else $error("internal reset low while pin driven");
   a_pin_hold: assert property ($fell(INT_RESET_O) |-> $past(PINS_I.reset_pin, 3))
      else $error("internal reset released while pin low");
   a_lock_drop: assert property (!PINS_I.synth_lock [*5] |-> !CLOCK_O.xtal_qualified)
      else $error("qualified without lock");
   a_qual_needs_en: assert property (!CLOCK_O.xtal_enable [*2] |-> !CLOCK_O.xtal_qualified)
      else $error("qualified while oscillator off");
   a_synth_fallback: assert property (
      $fell(CLOCK_O.xtal_qualified) && !$past(CLOCK_O.synth_clock_select)
      |-> ##[0:3] CLOCK_O.synth_clock_select)
      else $error("no fallback to synth clock");
   a_irq_global_mask: assert property ($past(GLOBAL_MASK_I) |-> IRQ_O == 6'h00)
      else $error("interrupt passed global mask");
   c_drive_end: cover property ($fell(RESET_PIN_OE_O));
   c_watchdog_vec: cover property ($fell(INT_RESET_O) && VECTOR_O == 2'h2);
   c_fallback: cover property ($rose(CLOCK_O.synth_clock_select) && !INT_RESET_O);
endmodule : clock_mode_reset_watchdog_checker

// ### tb/cmrw_pin_env.sv
// Purpose: pin-side model: reset pin wire, watchdog ticks, analog levels
// Assumes: pull-up on the reset pin
// Notes:   ticks toggle every 4 clocks, well under the clock/4 limit
module cmrw_pin_env (
   // clock
   input  wire logic                                    clk_i,
   // pin drivers
   input  wire logic                                    ext_low_i,
   input  wire logic                                    oe_i,
   input  wire logic                                    pin_i,
   // levels from the bench
   input  wire clock_mode_reset_watchdog_pkg::pins_type lvl_i,
   output clock_mode_reset_watchdog_pkg::pins_type      pins_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import clock_mode_reset_watchdog_pkg::*;
   logic [1:0] div = 2'h0;
   logic       tick = 1'b0;
   always @(posedge clk_i) begin
      div <= div + 2'h1;
      if (div == 2'h3) tick <= !tick;
   end
   always_comb begin
      pins_o = lvl_i;
      // wired-and of both drivers, pull-up when neither pulls low
      pins_o.reset_pin = !(ext_low_i || (oe_i && !pin_i));
      pins_o.intref_tick = tick;
      pins_o.xtal_tick = tick;
   end
endmodule : cmrw_pin_env

// ### tb/test_clock_mode_reset_watchdog.sv
// Purpose: directed regression of clock modes, reset sequence, watchdog
// Assumes: zero-wait AHB-Lite slave, pull-up on the reset pin
// Notes:   watchdog period 1 = 1024 ticks of 8 clocks each
`include "clock_mode_reset_watchdog_regs.svh"
module test_clock_mode_reset_watchdog;
   timeunit 1ns;
   timeprecision 1ns;
   import clock_mode_reset_watchdog_pkg::*;
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   logic          hsel = 1'b0;
   logic [31:0]   haddr = 32'h0;
   logic [1:0]    htrans = 2'h0;
   logic          hwrite = 1'b0;
   logic [31:0]   hwdata = 32'h0;
   logic          mask = 1'b0;
   logic          ext_low = 1'b0;
   pins_type      lvl = '0;
   pins_type      pins;
   logic [31:0]   hrdata;
   logic          hready;
   logic          pin;
   logic          oe;
   logic          irst;
   logic [1:0]    vec;
   clock_ctl_type cc;
   logic [5:0]    irq;
   logic [31:0]   rd;
   int            n_fail = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   initial forever #4 clk = !clk;
   cmrw_pin_env env_u (.clk_i(clk), .ext_low_i(ext_low), .oe_i(oe), .pin_i(pin),
      .lvl_i(lvl), .pins_o(pins));
   clock_mode_reset_watchdog dut_u (.CLK_I(clk), .NRST_I(nrst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .PINS_I(pins), .GLOBAL_MASK_I(mask),
      .RESET_PIN_O(pin), .RESET_PIN_OE_O(oe), .INT_RESET_O(irst), .VECTOR_O(vec),
      .CLOCK_O(cc), .IRQ_O(irq));
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   // a hang anywhere ends up here; the whole run needs about 16000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdc
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles
   task automatic wait_oe(output int m);
      m = 0;
      while (oe !== 1'b1) begin
         @(posedge clk);
         m++;
      end
   endtask : wait_oe
   task automatic wait_rel(output int n);
      n = 0;
      while (irst !== 1'b0) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_rel
   initial begin : main
      int n;
      int m;
      logic [31:0] wdc [2] = '{32'h1, 32'h9};
      logic [31:0] wdk [2] = '{32'h12, 32'h55};
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      wait_rel(n);
      check({31'h0, n >= 576}, 32'h1);
      check({30'h0, vec}, 32'h0);
      rdc(`XTAL_CTRL_OFS, 32'h2);
      rdc(`WD_CTRL_OFS, 32'h0);
      rdc(8'h14, 32'h0);
      lvl.synth_lock <= 1'b1;
      cycles(4);
      wr(`IRQ_EN_OFS, 32'h2);
      cycles(2);
      check({31'h0, irq[1]}, 32'h1);
      mask <= 1'b1;
      cycles(2);
      check({26'h0, irq}, 32'h0);
      mask <= 1'b0;
      wr(`STATUS_OFS, 32'h4);
      cycles(2);
      check({31'h0, irq[1]}, 32'h0);
      lvl.tick_req <= 1'b1;
      lvl.undervolt_req <= 1'b1;
      lvl.overtemp_req <= 1'b1;
      lvl.autonomous_req <= 1'b1;
      wr(`IRQ_EN_OFS, 32'h39);
      cycles(4);
      check({26'h0, irq}, 32'h39);
      wr(`IRQ_EN_OFS, 32'h0);
      // software order: divider first, oscillator enable after
      wr(`XTAL_CTRL_OFS, 32'h52);
      wr(`XTAL_CTRL_OFS, 32'h53);
      lvl.xtal_ok <= 1'b1;
      cycles(6);
      rdc(`STATUS_OFS, 32'hb);
      check({28'h0, cc.reference_divider}, 32'h5);
      wr(`XTAL_CTRL_OFS, 32'h51);
      cycles(2);
      check({31'h0, cc.synth_clock_select}, 32'h0);
      lvl.xtal_ok <= 1'b0;
      cycles(6);
      check({30'h0, cc.synth_clock_select, cc.xtal_qualified}, 32'h2);
      lvl.xtal_ok <= 1'b1;
      lvl.synth_lock <= 1'b0;
      cycles(6);
      check({31'h0, cc.xtal_qualified}, 32'h0);
      lvl.synth_lock <= 1'b1;
      wr(`XTAL_CTRL_OFS, 32'h52);
      cycles(6);
      check({31'h0, cc.xtal_qualified}, 32'h0);
      lvl.xtal_fail <= 1'b1;
      cycles(8);
      check({31'h0, irst}, 32'h0);
      // stop must be seen before the enable, or the monitor fires first
      lvl.stop <= 1'b1;
      cycles(3);
      wr(`XTAL_CTRL_OFS, 32'h53);
      cycles(8);
      check({30'h0, irst, cc.xtal_enable}, 32'h0);
      lvl.stop <= 1'b0;
      wait_oe(m);
      lvl.xtal_fail <= 1'b0;
      wait_rel(n);
      check({30'h0, vec}, 32'h1);
      wr(`WD_ARM_OFS, 32'h12);
      cycles(4);
      check({31'h0, irst}, 32'h0);
      wr(`WD_CTRL_OFS, 32'h1);
      cycles(4000);
      wr(`WD_ARM_OFS, 32'h55);
      wr(`WD_ARM_OFS, 32'haa);
      cycles(6000);
      check({31'h0, irst}, 32'h0);
      wait_oe(m);
      check({31'h0, m >= 2000 && m <= 2400}, 32'h1);
      wait_rel(n);
      check({30'h0, vec}, 32'h2);
      for (int i = 0; i < 2; i++) begin
         wr(`WD_CTRL_OFS, wdc[i]);
         wr(`WD_ARM_OFS, wdk[i]);
         wait_oe(m);
         check({31'h0, m <= 6}, 32'h1);
         wait_rel(n);
         check({30'h0, vec}, 32'h2);
      end
      ext_low <= 1'b1;
      cycles(1000);
      check({31'h0, irst}, 32'h1);
      ext_low <= 1'b0;
      wait_rel(n);
      check({30'h0, vec}, 32'h0);
      report_and_stop();
   end
endmodule : test_clock_mode_reset_watchdog
bind clock_mode_reset_watchdog clock_mode_reset_watchdog_checker chk_u (.CLK_I(CLK_I),
   .NRST_I(NRST_I), .PINS_I(PINS_I), .GLOBAL_MASK_I(GLOBAL_MASK_I), .RESET_PIN_O(RESET_PIN_O),
   .RESET_PIN_OE_O(RESET_PIN_OE_O), .INT_RESET_O(INT_RESET_O), .VECTOR_O(VECTOR_O),
   .CLOCK_O(CLOCK_O), .IRQ_O(IRQ_O));

// ### verilog/clock_mode_reset_watchdog.sv
// Purpose: clock mode control, reset sequencer and watchdog
// Assumes: CLK_I is the synthesized clock; pin-side inputs are asynchronous
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`include "clock_mode_reset_watchdog_regs.svh"
module clock_mode_reset_watchdog (
   // clock and reset
   input  wire logic                                   CLK_I,
   input  wire logic                                   NRST_I,
   // ahb-lite slave
   input  wire logic                                   HSEL,
   input  wire logic [31:0]                            HADDR,
   input  wire logic [1:0]                             HTRANS,
   input  wire logic                                   HWRITE,
   input  wire logic [2:0]                             HSIZE,
   input  wire logic [31:0]                            HWDATA,
   input  wire logic                                   HREADY,
   output logic      [31:0]                            HRDATA,
   output logic                                        HREADYOUT,
   output logic                                        HRESP,
   // pins and analog status
   input  wire clock_mode_reset_watchdog_pkg::pins_type PINS_I,
   input  wire logic                                   GLOBAL_MASK_I,
   output logic                                        RESET_PIN_O,
   output logic                                        RESET_PIN_OE_O,
   output logic                                        INT_RESET_O,
   output logic      [1:0]                             VECTOR_O,
   output clock_mode_reset_watchdog_pkg::clock_ctl_type CLOCK_O,
   output logic      [5:0]                             IRQ_O
);
   import clock_mode_reset_watchdog_pkg::*;

   pins_type      pin_meta;
   pins_type      pin;
   seq_state_type state;
   logic [9:0]    seq_count;
   logic          mon_pending;
   logic          wd_pending;
   logic [7:0]    xtal_ctrl;
   logic [6:0]    wd_ctrl;
   logic [5:0]    irq_en;
   logic          lock_flag;
   logic          xtal_flag;
   logic          xtal_qual;
   logic          lock_d;
   logic          key_armed;
   logic [23:0]   wd_count;
   logic          wd_tick_d;
   logic          wr_pend;
   logic [7:0]    wr_addr;
   logic          in_seq;
   logic          full_stop;
   logic          xtal_on;
   logic          mon_fail;
   logic          wd_on;
   logic          wd_tick;
   logic          wd_runs;
   logic          wd_timeout;
   logic          arm_wr;
   logic          bad_key;
   logic          early;
   logic          wd_fault;
   logic          source;
   logic [23:0]   limit;
   logic          next_qual;

   function automatic logic [23:0] wd_limit(input logic [2:0] period);
      logic [4:0] tap;
      tap = `WD_TAP_BASE + 5'(period) * `WD_TAP_STEP;
      return 24'h000001 << tap;
   endfunction : wd_limit

   function automatic logic [31:0] read_mux(input logic [7:0] ofs);
      read_mux = 32'h00000000;
      unique case (ofs)
         `XTAL_CTRL_OFS: read_mux = {24'h000000, xtal_ctrl};
         `WD_CTRL_OFS:   read_mux = {25'h0000000, wd_ctrl};
         `IRQ_EN_OFS:    read_mux = {26'h0000000, irq_en};
         `STATUS_OFS:    read_mux = {24'h000000, VECTOR_O, 2'h0, xtal_flag, lock_flag,
                                     xtal_qual, pin.synth_lock};
         default:        read_mux = 32'h00000000;
      endcase
   endfunction : read_mux

   // two flip-flops before any logic sees a pin
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pin_meta <= '0;
         pin      <= '0;
      end else begin
         pin_meta <= PINS_I;
         pin      <= pin_meta;
      end
   end

   assign in_seq    = (state != SEQ_IDLE);
   assign full_stop = pin.stop & ~wd_ctrl[`PSEUDO_BIT];
   assign xtal_on   = xtal_ctrl[`XTAL_EN_BIT] & ~full_stop;
   assign mon_fail  = xtal_on & pin.xtal_fail;
   assign wd_on     = (wd_ctrl[2:0] != 3'h0);
   assign limit     = wd_limit(wd_ctrl[2:0]);
   assign wd_tick   = wd_ctrl[`WD_SRC_BIT] ? pin.xtal_tick : pin.intref_tick;
   assign wd_runs   = ~pin.stop | (wd_ctrl[`PSEUDO_BIT] & wd_ctrl[`WD_SRC_BIT]
                                   & wd_ctrl[`WD_STOP_BIT]);
   assign wd_timeout = wd_on & (wd_count >= limit);
   assign arm_wr    = wr_pend & (wr_addr == `WD_ARM_OFS) & wd_on;
   assign bad_key   = arm_wr & (HWDATA[7:0] != `KEY_FIRST)
                             & (HWDATA[7:0] != `KEY_SECOND);
   assign early     = arm_wr & wd_ctrl[`WD_WIN_BIT]
                             & (wd_count < (limit - (limit >> 2)));
   assign wd_fault  = wd_timeout | bad_key | early;
   // pin seen low while idle is an external reset; during the drive it is our own
   assign source    = pin.power_fail | pin.illegal_addr | mon_fail | wd_fault
                      | (~pin.reset_pin & ~in_seq);
   assign next_qual = xtal_on & pin.synth_lock & pin.xtal_ok;

   // reset sequencer
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state     <= SEQ_DRIVE;
         seq_count <= 10'h000;
      end else begin
         unique case (state)
            SEQ_IDLE: begin
               if (source) begin
                  state     <= SEQ_DRIVE;
                  seq_count <= 10'h000;
               end
            end
            SEQ_DRIVE: begin
               // own pin drive is already kept out of source, so any source restarts
               if (source) begin
                  seq_count <= 10'h000;
               end else if (seq_count == `DRIVE_CYCLES - 10'd1) begin
                  state     <= SEQ_WAIT;
                  seq_count <= 10'h000;
               end else begin
                  seq_count <= seq_count + 10'd1;
               end
            end
            SEQ_WAIT: begin
               if (seq_count == `WAIT_CYCLES - 10'd1) begin
                  state     <= pin.reset_pin ? SEQ_IDLE : SEQ_HOLD;
                  seq_count <= 10'h000;
               end else begin
                  seq_count <= seq_count + 10'd1;
               end
            end
            SEQ_HOLD: begin
               if (pin.reset_pin) begin
                  state <= SEQ_IDLE;
               end
            end
         endcase
      end
   end

   // pending causes survive the sequence they started
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mon_pending <= 1'b0;
         wd_pending  <= 1'b0;
      end else if (state == SEQ_IDLE && !source) begin
         mon_pending <= 1'b0;
         wd_pending  <= 1'b0;
      end else begin
         mon_pending <= mon_pending | mon_fail;
         wd_pending  <= wd_pending | wd_fault;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RESET_PIN_O    <= 1'b0;
         RESET_PIN_OE_O <= 1'b1;
         INT_RESET_O    <= 1'b1;
         VECTOR_O       <= `VEC_COMMON;
      end else begin
         RESET_PIN_O    <= 1'b0;
         RESET_PIN_OE_O <= (state == SEQ_DRIVE) | (state == SEQ_IDLE && source);
         INT_RESET_O    <= in_seq | source;
         if (state == SEQ_WAIT && seq_count == `WAIT_CYCLES - 10'd1) begin
            if (!pin.reset_pin) begin
               VECTOR_O <= `VEC_COMMON;
            end else if (mon_pending) begin
               VECTOR_O <= `VEC_MONITOR;
            end else if (wd_pending) begin
               VECTOR_O <= `VEC_WATCHDOG;
            end else begin
               VECTOR_O <= `VEC_COMMON;
            end
         end
      end
   end

   // ahb-lite: address phase captured, write lands in the data phase
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         HRDATA    <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         wr_pend   <= HSEL & HREADY & HTRANS[1] & HWRITE;
         wr_addr   <= HADDR[7:0];
         if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
            HRDATA <= read_mux(HADDR[7:0]);
         end
      end
   end

   // control registers return to defaults while the internal reset stands
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         xtal_ctrl <= `XTAL_CTRL_RST;
         wd_ctrl   <= `WD_CTRL_RST;
         irq_en    <= `IRQ_EN_RST;
      end else if (in_seq) begin
         xtal_ctrl <= `XTAL_CTRL_RST;
         wd_ctrl   <= `WD_CTRL_RST;
         irq_en    <= `IRQ_EN_RST;
      end else begin
         if (wr_pend && wr_addr == `XTAL_CTRL_OFS) begin
            xtal_ctrl <= HWDATA[7:0];
         end
         if (wr_pend && wr_addr == `WD_CTRL_OFS) begin
            wd_ctrl <= HWDATA[6:0];
         end
         if (wr_pend && wr_addr == `IRQ_EN_OFS) begin
            irq_en <= HWDATA[5:0];
         end
         // hardware fallback wins over a software clear in the same cycle
         if (xtal_qual && !next_qual && !xtal_ctrl[`SYNTH_SEL_BIT]) begin
            xtal_ctrl[`SYNTH_SEL_BIT] <= 1'b1;
         end
      end
   end

   // qualification and change flags
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         xtal_qual <= 1'b0;
         lock_d    <= 1'b0;
         lock_flag <= 1'b0;
         xtal_flag <= 1'b0;
      end else begin
         xtal_qual <= next_qual;
         lock_d    <= pin.synth_lock;
         if (lock_d != pin.synth_lock) begin
            lock_flag <= 1'b1;
         end else if (wr_pend && wr_addr == `STATUS_OFS && HWDATA[2]) begin
            lock_flag <= 1'b0;
         end
         if (xtal_qual != next_qual) begin
            xtal_flag <= 1'b1;
         end else if (wr_pend && wr_addr == `STATUS_OFS && HWDATA[3]) begin
            xtal_flag <= 1'b0;
         end
      end
   end

   // watchdog counter and key sequence
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wd_count  <= 24'h000000;
         wd_tick_d <= 1'b0;
         key_armed <= 1'b0;
      end else begin
         wd_tick_d <= wd_tick;
         if (in_seq || !wd_on) begin
            wd_count  <= 24'h000000;
            key_armed <= 1'b0;
         end else if (arm_wr && HWDATA[7:0] == `KEY_FIRST) begin
            key_armed <= 1'b1;
         end else if (arm_wr && HWDATA[7:0] == `KEY_SECOND && key_armed) begin
            key_armed <= 1'b0;
            wd_count  <= 24'h000000;
         end else if (wd_runs && wd_tick && !wd_tick_d && !wd_timeout) begin
            wd_count <= wd_count + 24'h000001;
         end
      end
   end

   // clock selection and interrupt requests
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         CLOCK_O <= '0;
         IRQ_O   <= 6'h00;
      end else begin
         CLOCK_O.synth_clock_select     <= xtal_ctrl[`SYNTH_SEL_BIT];
         CLOCK_O.xtal_enable            <= xtal_on;
         CLOCK_O.xtal_qualified         <= xtal_qual;
         CLOCK_O.tick_source            <= xtal_ctrl[`TICK_SRC_BIT];
         CLOCK_O.watchdog_source_select <= wd_ctrl[`WD_SRC_BIT];
         CLOCK_O.reference_divider      <= xtal_ctrl[`REF_DIV_LSB +: 4];
         IRQ_O <= {GLOBAL_MASK_I ? 6'h00 :
                   irq_en & {pin.autonomous_req, pin.overtemp_req, pin.undervolt_req,
                             xtal_flag, lock_flag, pin.tick_req}};
      end
   end

endmodule : clock_mode_reset_watchdog

// ### verilog/clock_mode_reset_watchdog_pkg.sv
// Purpose: types of the clock/reset/watchdog unit
// Assumes: nothing
// Notes:   constants live in the _regs header
package clock_mode_reset_watchdog_pkg;
   typedef struct packed {
      logic reset_pin;
      logic power_fail;
      logic illegal_addr;
      logic synth_lock;
      logic xtal_ok;
      logic xtal_fail;
      logic stop;
      logic intref_tick;
      logic xtal_tick;
      logic undervolt_req;
      logic overtemp_req;
      logic autonomous_req;
      logic tick_req;
   } pins_type;
   typedef struct packed {
      logic       synth_clock_select;
      logic       xtal_enable;
      logic       xtal_qualified;
      logic       tick_source;
      logic       watchdog_source_select;
      logic [3:0] reference_divider;
   } clock_ctl_type;
   typedef enum logic [3:0] {
      SEQ_IDLE  = 4'b0001,
      SEQ_DRIVE = 4'b0010,
      SEQ_WAIT  = 4'b0100,
      SEQ_HOLD  = 4'b1000
   } seq_state_type;
endpackage : clock_mode_reset_watchdog_pkg

// ### verilog/clock_mode_reset_watchdog_regs.svh
// Purpose: offsets, fields, reset values and counts of the clock/reset/watchdog unit
// Assumes: 32-bit AHB-Lite register words, byte addresses below
// Notes:   included by the design file
// Functional notes
// - synth external mode: bus clock from synth, reference and qualification from oscillator.
// - oscillator qualified status clears whenever synth lock drops.
// - bypass external mode runs bus clock straight from the oscillator.
// - losing qualification in bypass mode sets synth select again by hardware.
// - watchdog and tick counters may run from internal reference or oscillator.
// - only clock monitor and watchdog resets have local enables.
// - any reset source drives the reset pin low for 512 cycles.
// - wait 64 more cycles after release, then sample the pin.
// - pin low gives common vector; else monitor, then watchdog, else common.
// - internal reset spans the 576-cycle sequence, longer while pin held low.
// - enabled oscillator lost or too slow raises a clock monitor reset.
// - full stop disables oscillator and clock monitor.
// - watchdog runs in stop only with pseudo halt, oscillator source, run-in-stop.
// - 3-bit period field gives seven periods, zero disables.
// - key 55 then aa restarts the period; timeout resets.
// - any other value written to the arm register while the watchdog is enabled resets.
// - windowed mode: service before last quarter of period resets at once.
// - six interrupt sources, each locally enabled, all under global mask.
// - lock toggle sets lock change flag; writing one clears it.
// - oscillator enable zero holds qualified status at zero.
`ifndef CLOCK_MODE_RESET_WATCHDOG_REGS_SVH
`define CLOCK_MODE_RESET_WATCHDOG_REGS_SVH
`define XTAL_CTRL_OFS   8'h00
`define WD_CTRL_OFS     8'h04
`define WD_ARM_OFS      8'h08
`define IRQ_EN_OFS      8'h0c
`define STATUS_OFS      8'h10
`define XTAL_EN_BIT     0
`define SYNTH_SEL_BIT   1
`define TICK_SRC_BIT    2
`define REF_DIV_LSB     4
`define WD_WIN_BIT      3
`define WD_SRC_BIT      4
`define WD_STOP_BIT     5
`define PSEUDO_BIT      6
`define XTAL_CTRL_RST   8'h02
`define WD_CTRL_RST     7'h00
`define IRQ_EN_RST      6'h00
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'haa
`define DRIVE_CYCLES    10'd512
`define WAIT_CYCLES     10'd64
`define WD_TAP_BASE     5'd8
`define WD_TAP_STEP     5'd2
`define VEC_COMMON      2'h0
`define VEC_MONITOR     2'h1
`define VEC_WATCHDOG    2'h2
`endif
